//--- verilog/spec_classifier.sv
// Per-port error classifier: sorts link, data link and transaction faults.
// Contract
// R1: Each port classifies independently of others.
// R2: Primary address TLP claimed inside window.
// R3: Primary ID TLP claimed by aperture/own ID.
// R4: Implicitly routed TLPs are always claimed.
// R5: Physical link faults give correctable processing.
// R6: Framing violations give correctable processing.
// R7: Physical error suppresses data link errors.
// R8: Bad TLP: EDB/LCRC/sequence conditions.
// R9: Bad TLP discarded, correctable, not function-specific.
// R10: Bad-LCRC DLLP discarded, correctable.
// R11: Unmatched ACK/NAK sequence: discard, uncorrectable.
// R12: Surprise link down gives uncorrectable; code clears it if an advisory TLP error lands in the same cycle.
// R13: Lower-layer errors suppress transaction errors.
// R14: Poisoned TLP sets side's parity flag.
// R15: Poisoned advisory when nonfatal and role fits.
// R16: Poisoned header logged; forwarded or dropped.
// R17: ECRC advisory only nonfatal intermediate link receiver.
// R18: ECRC logs header; forward, ultimate drops.
// R19: Non-posted UR completion by claimer or 0.
// R20: No completion time-out detection needed.
// R21: Completer abort only recorded as access-control.
// R22: One-cycle strobes with function and log enable.
`timescale 1ns/1ps
module spec_classifier
    import spec_pkg::*;
(
    input  wire logic           clk_sys_i,          // Port core clock, 200 MHz.
    input  wire logic           rst_n_i,            // Synchronous reset, active low.
    input  wire logic           pkt_valid_i,        // One-cycle pulse: a packet's checks are ready.
    input  wire spec_phy_err_t  phy_err_i,          // Physical layer faults of this packet.
    input  wire logic           link_err_valid_i,   // Pulse: a link fault not tied to a packet.
    input  wire spec_phy_err_t  link_err_i,         // Faults of that link event.
    input  wire spec_dll_info_t dll_i,              // Data link layer observations.
    input  wire logic [11:0]    next_rcv_seq_i,     // Expected receive sequence number.
    input  wire logic           surprise_down_i,    // Pulse: unexpected link loss.
    input  wire spec_tlp_info_t tlp_i,              // Transaction layer attributes.
    input  wire spec_cfg_t      cfg_i,              // Bridge configuration.
    output spec_report_t        report_o,           // Registered classification report.
    output logic                claim_o,            // Registered claim result of last TLP.
    output logic                ur_cpl_o,           // Pulse: send a UR completion.
    output logic [2:0]          ur_cpl_func_o,      // Function that sends the UR completion.
    output logic                pri_parity_set_o,   // Pulse: set primary detected parity flag.
    output logic                sec_parity_set_o,   // Pulse: set secondary detected parity flag.
    output logic                acs_err_o           // Pulse: record an access-control error.
);
    // R1: this module holds only per-port state; no input comes from other ports.

    // Claim result of the current TLP.
    logic claim_w;

    spec_claim u_claim (
        .tlp_i   (tlp_i),
        .cfg_i   (cfg_i),
        .claim_o (claim_w)
    );

    // Registered outputs.
    spec_report_t report_ff;        // Current report.
    logic         claim_ff;         // Last claim decision.
    logic         ur_cpl_ff;        // UR completion strobe.
    logic [2:0]   ur_cpl_func_ff;   // UR completion function.
    logic         pri_par_ff;       // Primary parity strobe.
    logic         sec_par_ff;       // Secondary parity strobe.
    logic         acs_err_ff;       // Access-control strobe.

    // Next values.
    spec_report_t nxt_report;
    logic         nxt_ur_cpl;
    logic [2:0]   nxt_ur_cpl_func;
    logic         nxt_pri_par;
    logic         nxt_sec_par;
    logic         nxt_acs_err;

    // Layer-level decisions, kept visible for the assertions.
    logic phy_err_w;      // Physical error on this packet.
    logic link_ev_w;      // Physical link fault outside a packet.
    logic bad_tlp_w;      // Bad TLP before suppression.
    logic bad_dllp_w;     // Bad DLLP before suppression.
    logic dl_proto_w;     // Protocol error before suppression.
    logic dll_err_w;      // Any data link error after suppression.
    logic tl_ok_w;        // Transaction checks allowed.
    logic poison_adv_w;   // Poisoned TLP is advisory.
    logic ecrc_adv_w;     // ECRC failure is advisory.
    logic ur_adv_w;       // Unsupported request is advisory.

    // Layer detection. A packet flagged by a lower layer hides higher-layer errors.
    always_comb begin
        phy_err_w  = pkt_valid_i && (|phy_err_i); // R5 R6
        link_ev_w  = link_err_valid_i && (|link_err_i); // R5
        bad_tlp_w  = dll_i.is_tlp && ((dll_i.ends_edb && !dll_i.lcrc_inv_ok) ||
                     (!dll_i.ends_edb && !dll_i.lcrc_ok) ||
                     (dll_i.seq_num != next_rcv_seq_i && !dll_i.seq_duplicate)); // R8
        bad_dllp_w = dll_i.is_dllp && !dll_i.lcrc_ok; // R10
        dl_proto_w = dll_i.is_dllp && dll_i.lcrc_ok && dll_i.is_acknak &&
                     !dll_i.acknak_unacked_match && !dll_i.acknak_ackd_match; // R11
        dll_err_w  = pkt_valid_i && !phy_err_w && (bad_tlp_w || bad_dllp_w || dl_proto_w); // R7
        tl_ok_w    = pkt_valid_i && dll_i.is_tlp && !phy_err_w && !dll_err_w; // R13
        // Severity nonfatal and the right role (for UR, a non-posted request) make an error advisory.
        poison_adv_w = !cfg_i.sev_poison_fatal && (tlp_i.from_link || tlp_i.ultimate_rcvr); // R15
        ecrc_adv_w   = !cfg_i.sev_ecrc_fatal && tlp_i.from_link && !tlp_i.ultimate_rcvr; // R17
        ur_adv_w     = !cfg_i.sev_ur_fatal && tlp_i.non_posted;
    end

    // Classification. Priority: physical, data link, transaction; surprise down sets uncorrectable unless an advisory poisoned/ECRC/UR error clears it.
    // The order matters: lower layers win so one fault gives one report.
    always_comb begin
        nxt_report        = '0;
        nxt_report.action = SPEC_ACT_FORWARD;
        nxt_ur_cpl        = 1'b0;
        nxt_ur_cpl_func   = SPEC_UR_DEFAULT_FUNC;
        nxt_pri_par       = 1'b0;
        nxt_sec_par       = 1'b0;
        nxt_acs_err       = 1'b0;
        if (surprise_down_i) begin
            nxt_report.uncorr = 1'b1; // R12
        end
        if (phy_err_w || link_ev_w) begin
            nxt_report.corr = 1'b1; // R5 R6
            if (phy_err_w) begin
                nxt_report.action = SPEC_ACT_DISCARD;
            end
        end else if (dll_err_w) begin
            nxt_report.action = SPEC_ACT_DISCARD; // R9 R10 R11
            if (dl_proto_w) begin
                nxt_report.uncorr = 1'b1; // R11
            end else begin
                nxt_report.corr = 1'b1; // R9 R10
            end
        end else if (tl_ok_w) begin
            if (tlp_i.poisoned) begin
                // Parity flag of the side it arrived on.
                nxt_pri_par = !tlp_i.secondary_side; // R14
                nxt_sec_par = tlp_i.secondary_side; // R14
                nxt_report.func_specific = 1'b1;
                nxt_report.func          = tlp_i.func;
                nxt_report.hdr_log       = 1'b1; // R16
                nxt_report.corr          = poison_adv_w; // R15
                nxt_report.uncorr        = !poison_adv_w; // R15
                nxt_report.action = tlp_i.ultimate_rcvr ? SPEC_ACT_DROP : SPEC_ACT_FORWARD; // R16
            end else if (tlp_i.ecrc_fail) begin
                nxt_report.hdr_log = 1'b1; // R18
                nxt_report.corr    = ecrc_adv_w; // R17
                nxt_report.uncorr  = !ecrc_adv_w; // R17
                nxt_report.action  = tlp_i.ultimate_rcvr ? SPEC_ACT_DROP : SPEC_ACT_FORWARD; // R18
            end else if (tlp_i.acs_violation) begin
                // Completer abort is reported only as an access-control error.
                nxt_acs_err = 1'b1; // R21
                nxt_report.action = SPEC_ACT_DROP;
            end else if (tlp_i.unsupported) begin
                nxt_report.func_specific = claim_w;
                nxt_report.func          = claim_w ? tlp_i.func : SPEC_UR_DEFAULT_FUNC;
                nxt_report.hdr_log       = 1'b1; // R19
                nxt_report.corr          = ur_adv_w;
                nxt_report.uncorr        = !ur_adv_w;
                nxt_report.action        = SPEC_ACT_DROP;
                nxt_ur_cpl      = tlp_i.non_posted; // R19
                nxt_ur_cpl_func = claim_w ? tlp_i.func : SPEC_UR_DEFAULT_FUNC; // R19
            end
        end
        // R20: no completion time-out logic, the bridge never issues requests.
    end

    // Report register: every strobe lasts exactly one cycle.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            report_ff <= '0;
        end else begin
            report_ff <= nxt_report; // R22
        end
    end

    // Side-effect strobes for the status flags and completion generator.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ur_cpl_ff      <= SPEC_RST_VAL;
            ur_cpl_func_ff <= SPEC_UR_DEFAULT_FUNC;
            pri_par_ff     <= SPEC_RST_VAL;
            sec_par_ff     <= SPEC_RST_VAL;
            acs_err_ff     <= SPEC_RST_VAL;
        end else begin
            ur_cpl_ff      <= nxt_ur_cpl;
            ur_cpl_func_ff <= nxt_ur_cpl_func;
            pri_par_ff     <= nxt_pri_par;
            sec_par_ff     <= nxt_sec_par;
            acs_err_ff     <= nxt_acs_err;
        end
    end

    // Claim result is held until the next TLP so a consumer can sample it late.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            claim_ff <= SPEC_RST_VAL;
        end else if (pkt_valid_i && dll_i.is_tlp) begin
            claim_ff <= claim_w; // R2 R3 R4
        end
    end

    assign report_o         = report_ff;
    assign claim_o          = claim_ff;
    assign ur_cpl_o         = ur_cpl_ff;
    assign ur_cpl_func_o    = ur_cpl_func_ff;
    assign pri_parity_set_o = pri_par_ff;
    assign sec_parity_set_o = sec_par_ff;
    assign acs_err_o        = acs_err_ff;

    // Physical faults produce a correctable strobe next cycle.
    a_phy_corr_strobe: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R5
        (pkt_valid_i && |phy_err_i) |=> report_o.corr && report_o.action == SPEC_ACT_DISCARD)
        else $error("physical fault not correctable");

    // Framing error alone also gives correctable processing.
    a_framing_corr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R6
        (pkt_valid_i && phy_err_i.framing_err) |=> report_o.corr)
        else $error("framing error not correctable");

    // A physical fault hides a protocol error on the same packet.
    a_dll_suppressed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R7
        (pkt_valid_i && |phy_err_i && !surprise_down_i) |=> !report_o.uncorr)
        else $error("data link error not suppressed");

    // Bad TLP is discarded, correctable, not function specific.
    a_bad_tlp: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R9
        (pkt_valid_i && !(|phy_err_i) && dll_i.is_tlp && !dll_i.ends_edb && !dll_i.lcrc_ok)
        |=> report_o.corr && !report_o.func_specific && report_o.action == SPEC_ACT_DISCARD)
        else $error("bad TLP misclassified");

    // Protocol error discards and is uncorrectable.
    a_dl_proto: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R11
        (dll_err_w && dl_proto_w) |=> report_o.uncorr && report_o.action == SPEC_ACT_DISCARD)
        else $error("protocol error misclassified");

    // Surprise link down is uncorrectable.
    a_surprise_down: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R12
        surprise_down_i |=> report_o.uncorr)
        else $error("surprise down not uncorrectable");

    // Lower-layer error stops transaction strobes.
    a_tl_suppressed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R13
        (pkt_valid_i && (|phy_err_i || dll_err_w)) |=> !pri_parity_set_o && !sec_parity_set_o && !ur_cpl_o)
        else $error("transaction error not suppressed");

    // Poisoned TLP sets the parity flag of its arrival side.
    a_poison_side: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R14
        (tl_ok_w && tlp_i.poisoned) |=> (sec_parity_set_o == $past(tlp_i.secondary_side))
        && (pri_parity_set_o != sec_parity_set_o) && report_o.hdr_log)
        else $error("parity flag side wrong");

    // Unsupported non-posted request answered by claimer or function 0.
    a_ur_cpl: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R19
        (tl_ok_w && tlp_i.unsupported && !tlp_i.poisoned && !tlp_i.ecrc_fail && !tlp_i.acs_violation
         && tlp_i.non_posted) |=> ur_cpl_o && ur_cpl_func_o == ($past(claim_w) ? $past(tlp_i.func)
         : SPEC_UR_DEFAULT_FUNC))
        else $error("UR completion missing or wrong function");

    // Access-control violation never raises the UR completion.
    a_acs_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R21
        acs_err_o |-> !ur_cpl_o && !report_o.corr)
        else $error("access error reported as other class");
endmodule

//--- include/spec_pkg.sv
// Package with shared types and constants for the switch port error classifier.
package spec_pkg;

    // Width of a TLP address compared against the base/limit window.
    localparam int SPEC_ADDR_W     = 64;
    // Width of a routing ID (bus/device/function).
    localparam int SPEC_ID_W       = 16;
    // Width of a link sequence number.
    localparam int SPEC_SEQ_W      = 12;
    // Field positions inside a routing ID.
    localparam int SPEC_ID_BUS_MSB = 15;
    localparam int SPEC_ID_BUS_LSB = 8;
    // Function that answers an unclaimed unsupported request.
    localparam logic [2:0] SPEC_UR_DEFAULT_FUNC = 3'h0;
    // Reset value of every strobe and flag.
    localparam logic SPEC_RST_VAL = 1'b0;

    // How a TLP is routed.
    typedef enum logic [1:0] {
        SPEC_RT_ADDR,
        SPEC_RT_ID,
        SPEC_RT_IMPL
    } spec_route_t;

    // What happens to the packet.
    typedef enum logic [1:0] {
        SPEC_ACT_FORWARD,
        SPEC_ACT_DISCARD,
        SPEC_ACT_DROP
    } spec_action_t;

    // Physical layer fault flags for one received packet or link event.
    typedef struct packed {
        logic decode_err;
        logic symbol_lock_lost;
        logic elastic_ovf_unf;
        logic deskew_fail;
        logic framing_err;
    } spec_phy_err_t;

    // Data link layer observations for one received packet.
    typedef struct packed {
        logic                  is_tlp;
        logic                  is_dllp;
        logic                  ends_edb;
        logic                  lcrc_ok;
        logic                  lcrc_inv_ok;
        logic                  seq_duplicate;
        logic [SPEC_SEQ_W-1:0] seq_num;
        logic                  is_acknak;
        logic                  acknak_unacked_match;
        logic                  acknak_ackd_match;
    } spec_dll_info_t;

    // Transaction layer attributes of a received TLP.
    typedef struct packed {
        logic                   secondary_side;
        spec_route_t            route;
        logic [SPEC_ADDR_W-1:0] addr;
        logic [SPEC_ID_W-1:0]   dest_id;
        logic                   poisoned;
        logic                   ecrc_fail;
        logic                   unsupported;
        logic                   non_posted;
        logic                   acs_violation;
        logic                   from_link;
        logic                   ultimate_rcvr;
        logic [2:0]             func;
    } spec_tlp_info_t;

    // Bridge configuration used for claiming and severity.
    typedef struct packed {
        logic [SPEC_ADDR_W-1:0] mem_base;
        logic [SPEC_ADDR_W-1:0] mem_limit;
        logic [7:0]             sec_bus;
        logic [7:0]             sub_bus;
        logic [SPEC_ID_W-1:0]   own_id;
        logic                   sev_poison_fatal;
        logic                   sev_ecrc_fatal;
        logic                   sev_ur_fatal;
    } spec_cfg_t;

    // Report toward reporting and logging logic.
    typedef struct packed {
        logic         corr;
        logic         uncorr;
        logic         func_specific;
        logic [2:0]   func;
        logic         hdr_log;
        spec_action_t action;
    } spec_report_t;

endpackage

//--- verilog/spec_claim.sv
// Claim decision of the bridge function for one received TLP.
`timescale 1ns/1ps
module spec_claim
    import spec_pkg::*;
(
    input  wire spec_tlp_info_t tlp_i,   // Attributes of the TLP.
    input  wire spec_cfg_t      cfg_i,   // Bridge window and bus aperture.
    output logic                claim_o  // High when the bridge claims the TLP.
);
    // Bus number carried in the destination ID.
    logic [7:0] dest_bus;
    assign dest_bus = tlp_i.dest_id[SPEC_ID_BUS_MSB:SPEC_ID_BUS_LSB];

    // Pure combinational decision so the classifier sees it in the same cycle.
    always_comb begin
        claim_o = 1'b0;
        case (tlp_i.route)
            SPEC_RT_ADDR: begin
                claim_o = tlp_i.secondary_side ||
                          (tlp_i.addr >= cfg_i.mem_base && tlp_i.addr <= cfg_i.mem_limit); // R2
            end
            SPEC_RT_ID: begin
                claim_o = tlp_i.secondary_side ||
                          (dest_bus >= cfg_i.sec_bus && dest_bus <= cfg_i.sub_bus) ||
                          (tlp_i.dest_id == cfg_i.own_id); // R3
            end
            SPEC_RT_IMPL: begin
                claim_o = 1'b1; // R4
            end
            default: begin
                claim_o = 1'b0;
            end
        endcase
    end
endmodule

//--- verification/spec_link_partner.sv
// Link partner model that delivers received packets to the classifier.
`timescale 1ns/1ps
module spec_link_partner
    import spec_pkg::*;
(
    input  wire logic      clk_sys_i,   // Port core clock.
    output logic           pkt_valid_o, // One-cycle strobe: a packet has arrived.
    output spec_phy_err_t  phy_err_o,   // Physical faults seen on the packet.
    output spec_dll_info_t dll_o,       // Data link observations of the packet.
    output spec_tlp_info_t tlp_o        // Transaction attributes of the packet.
);
    // Everything starts quiet so the classifier never sees an unknown strobe.
    initial begin
        pkt_valid_o = 1'b0;
        phy_err_o   = '0;
        dll_o       = '0;
        tlp_o       = '0;
    end

    // One packet for one cycle; afterwards the fields are scrambled, because a stale copy would hide
    // a classifier that samples them outside the strobe.
    task automatic send(input spec_phy_err_t p, input spec_dll_info_t d, input spec_tlp_info_t t);
        @(posedge clk_sys_i);
        pkt_valid_o <= 1'b1;
        phy_err_o   <= p;
        dll_o       <= d;
        tlp_o       <= t;
        @(posedge clk_sys_i);
        pkt_valid_o <= 1'b0;
        phy_err_o   <= spec_phy_err_t'(~p);
        dll_o       <= spec_dll_info_t'(~d);
        tlp_o       <= spec_tlp_info_t'(~t);
    endtask
endmodule

//--- verification/test_spec_classifier.sv
// Self-checking testbench for the switch port error classifier.
`timescale 1ns/1ps
module test_spec_classifier
    import spec_pkg::*;
;
    localparam logic [11:0] SEQ = 12'h010; // Sequence number the receiver expects next.
    logic           clk, rst_n, pkt_valid, link_err_valid, surprise_down; // Clock, reset and strobes.
    logic           claim, ur_cpl, pri_set, sec_set, acs_err;             // Design outputs.
    logic [2:0]     ur_func;                                              // Function of the UR completion.
    spec_phy_err_t  phy_w, link_err, p;                                   // Wires and working copy.
    spec_dll_info_t dll_w, d;                                             // Data link wire and copy.
    spec_tlp_info_t tlp_w, t;                                             // Transaction wire and copy.
    spec_cfg_t      cfg, cfg_n;                                           // Applied and next configuration.
    spec_report_t   report;                                               // Classification report.
    int             n_errors, samples_checked, cycles;                    // Counters.

    spec_link_partner i_spec_link_partner (.clk_sys_i(clk), .pkt_valid_o(pkt_valid), .phy_err_o(phy_w),
        .dll_o(dll_w), .tlp_o(tlp_w));
    spec_classifier i_spec_classifier (.clk_sys_i(clk), .rst_n_i(rst_n), .pkt_valid_i(pkt_valid),
        .phy_err_i(phy_w), .link_err_valid_i(link_err_valid), .link_err_i(link_err), .dll_i(dll_w),
        .next_rcv_seq_i(SEQ), .surprise_down_i(surprise_down), .tlp_i(tlp_w), .cfg_i(cfg),
        .report_o(report), .claim_o(claim), .ur_cpl_o(ur_cpl), .ur_cpl_func_o(ur_func),
        .pri_parity_set_o(pri_set), .sec_parity_set_o(sec_set), .acs_err_o(acs_err));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Cycle ceiling; the whole run needs about 110 cycles, so a hang is cut well before this.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end

    // Compares one value and counts the result.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A clean, in-order TLP, implicitly routed, taken from the link.
    task automatic base();
        p = '0;
        d = '0;
        d.is_tlp = 1'b1;
        d.lcrc_ok = 1'b1;
        d.seq_num = SEQ;
        t = '0;
        t.route = SPEC_RT_IMPL;
        t.func = 3'h5;
        t.from_link = 1'b1;
    endtask

    // Sends the working packet; returns one cycle after it was taken, while the report stands.
    task automatic pkt();
        @(posedge clk);
        cfg <= cfg_n;
        #1;
        check(report.corr | report.uncorr, 1'b0);
        i_spec_link_partner.send(p, d, t);
        #1;
    endtask

    // Judges the strobes and the packet action of the standing report.
    task automatic rep(input logic c, input logic u, input spec_action_t a);
        check({report.corr, report.uncorr, report.action}, {c, u, a});
    endtask

    // Raises a packet-less link event or a surprise link loss for one cycle.
    task automatic event_pulse(input logic down);
        @(posedge clk);
        link_err_valid <= ~down;
        surprise_down <= down;
        @(posedge clk);
        link_err_valid <= 1'b0;
        surprise_down <= 1'b0;
        #1;
        check({report.corr, report.uncorr}, {~down, down});
    endtask

    task automatic claim_one(input logic sec, input spec_route_t rt, input logic [63:0] v, input logic exp);
        base();
        t.secondary_side = sec;
        t.route = rt;
        t.addr = v;
        t.dest_id = v[15:0];
        pkt();
        check(claim, exp);
    endtask

    // Window edges, bus aperture edges, own ID and the always-claimed cases.
    task automatic t_claim();
        claim_one(1'b0, SPEC_RT_ADDR, 64'h1000, 1'b1);
        claim_one(1'b0, SPEC_RT_ADDR, 64'h1fff, 1'b1);
        claim_one(1'b0, SPEC_RT_ADDR, 64'h2000, 1'b0);
        claim_one(1'b0, SPEC_RT_ADDR, 64'h0fff, 1'b0);
        claim_one(1'b1, SPEC_RT_ADDR, 64'h0000, 1'b1);
        claim_one(1'b0, SPEC_RT_ID, 64'h0200, 1'b1);
        claim_one(1'b0, SPEC_RT_ID, 64'h05ff, 1'b1);
        claim_one(1'b0, SPEC_RT_ID, 64'h0600, 1'b0);
        claim_one(1'b0, SPEC_RT_ID, 64'h0108, 1'b1);
        claim_one(1'b1, SPEC_RT_ID, 64'h0600, 1'b1);
        claim_one(1'b0, SPEC_RT_IMPL, 64'h0600, 1'b1);
    endtask

    // Each physical fault on a packet that is also bad and poisoned: only the physical error counts.
    task automatic t_phy();
        for (int i = 0; i < 5; i++) begin
            base();
            p = spec_phy_err_t'(5'h01 << i);
            d.lcrc_ok = 1'b0;
            t.poisoned = 1'b1;
            pkt();
            rep(1'b1, 1'b0, SPEC_ACT_DISCARD);
            check({pri_set, report.func_specific}, 2'h0);
        end
        // A protocol error on an ACK/NAK under a physical fault must not turn uncorrectable.
        d.is_tlp = 1'b0;
        d.is_dllp = 1'b1;
        d.lcrc_ok = 1'b1;
        d.is_acknak = 1'b1;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_DISCARD);
        link_err = '0;
        link_err.deskew_fail = 1'b1;
        event_pulse(1'b0);
    endtask

    // Bad TLP variants, a harmless duplicate, and DLLP faults.
    task automatic t_dll();
        base();
        d.lcrc_ok = 1'b0;
        t.poisoned = 1'b1;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_DISCARD);
        check({report.func_specific, pri_set}, 2'h0);
        base();
        d.ends_edb = 1'b1;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_DISCARD);
        base();
        d.seq_num = SEQ + 12'h001;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_DISCARD);
        d.seq_duplicate = 1'b1;
        pkt();
        rep(1'b0, 1'b0, SPEC_ACT_FORWARD);
        base();
        d.is_tlp = 1'b0;
        d.is_dllp = 1'b1;
        d.lcrc_ok = 1'b0;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_DISCARD);
        d.lcrc_ok = 1'b1;
        d.is_acknak = 1'b1;
        pkt();
        rep(1'b0, 1'b1, SPEC_ACT_DISCARD);
        d.acknak_ackd_match = 1'b1;
        pkt();
        rep(1'b0, 1'b0, SPEC_ACT_FORWARD);
        event_pulse(1'b1);
    endtask

    // Poisoned and ECRC cases in both roles and both severities.
    task automatic t_tl();
        base();
        t.poisoned = 1'b1;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_FORWARD);
        check({report.hdr_log, report.func_specific, report.func, pri_set, sec_set}, 7'h76);
        cfg_n.sev_poison_fatal = 1'b1;
        t.secondary_side = 1'b1;
        t.from_link = 1'b0;
        pkt();
        rep(1'b0, 1'b1, SPEC_ACT_FORWARD);
        check({report.hdr_log, pri_set, sec_set}, 3'h5);
        cfg_n.sev_poison_fatal = 1'b0;
        t.ultimate_rcvr = 1'b1;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_DROP);
        base();
        t.ecrc_fail = 1'b1;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_FORWARD);
        check(report.hdr_log, 1'b1);
        t.ultimate_rcvr = 1'b1;
        pkt();
        rep(1'b0, 1'b1, SPEC_ACT_DROP);
        cfg_n.sev_ecrc_fatal = 1'b1;
        t.ultimate_rcvr = 1'b0;
        pkt();
        rep(1'b0, 1'b1, SPEC_ACT_FORWARD);
        cfg_n.sev_ecrc_fatal = 1'b0;
    endtask

    // Claimed and unclaimed non-posted UR, then an access-control violation.
    task automatic t_ur();
        base();
        t.route = SPEC_RT_ADDR;
        t.addr = 64'h1000;
        t.unsupported = 1'b1;
        t.non_posted = 1'b1;
        pkt();
        rep(1'b1, 1'b0, SPEC_ACT_DROP);
        check({ur_cpl, ur_func, report.func_specific, report.hdr_log}, 6'h37);
        t.addr = 64'h3000;
        pkt();
        check({ur_cpl, ur_func, report.func_specific, report.hdr_log}, 6'h21);
        base();
        t.acs_violation = 1'b1;
        pkt();
        rep(1'b0, 1'b0, SPEC_ACT_DROP);
        check(acs_err, 1'b1);
    endtask

    // Reset for six cycles, then the scenarios in turn.
    initial begin
        rst_n = 1'b0;
        link_err_valid = 1'b0;
        surprise_down = 1'b0;
        link_err = '0;
        cfg_n = '0;
        cfg_n.mem_base = 64'h1000;
        cfg_n.mem_limit = 64'h1fff;
        cfg_n.sec_bus = 8'h02;
        cfg_n.sub_bus = 8'h05;
        cfg_n.own_id = 16'h0108;
        cfg = cfg_n;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_claim();
        t_phy();
        t_dll();
        t_tl();
        t_ur();
        stop_test();
    end
endmodule
